// ---- src/rs_front_pkg.sv ----
// Constants and types shared by the decoder front end
package rs_front_pkg;
    localparam int SYM_W = 8;                // Symbol width
    localparam int N_SYM = 118;              // Symbols per word
    localparam int K_SYM = 102;              // Message symbols per word
    localparam int SYND_CNT = 16;            // Syndrome values (2t)
    localparam int SYND_PAR = 1;             // Symbols absorbed per cycle
    localparam int BUF_DEPTH = 198;          // Message buffer bytes
    localparam int PTR_W = 8;                // Buffer pointer width
    localparam int CNT_W = 7;                // Symbol counter width
    localparam logic [7:0] GF_POLY_LOW = 8'h1D; // Low byte of 0x11D
    localparam int LATENCY_CYCLES = 97;      // Last input to first output
    localparam int ISSUE_LEAD = 3;           // Timer, read and output stages
    localparam logic [6:0] LAT_RELOAD = 7'(LATENCY_CYCLES - ISSUE_LEAD);
    localparam logic [4:0] ERR_COUNT_NONE = 5'h00; // No symbol corrected
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LAST = 8'h08;
    localparam int CTRL_PAUSE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int LAST_FAIL_BIT = 0;
    localparam int LAST_COUNT_LSB = 8;
    localparam int LAST_BUSY_BIT = 16;
    localparam int LAST_HOLD_BIT = 17;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Output engine states
    typedef enum logic [1:0] {
        OUT_IDLE = 2'b01,
        OUT_RUN = 2'b10
    } out_state_t;
endpackage

// ---- src/rs_msg_buffer.sv ----
// Dual-port message buffer with registered read data
module rs_msg_buffer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [rs_front_pkg::PTR_W-1:0] wrAddr,
    input wire logic [rs_front_pkg::SYM_W-1:0] wrData,
    input wire logic rdEn,
    input wire logic [rs_front_pkg::PTR_W-1:0] rdAddr,
    output logic [rs_front_pkg::SYM_W-1:0] rdData
);
    // Storage, one byte per entry
    logic [rs_front_pkg::SYM_W-1:0] mem [rs_front_pkg::BUF_DEPTH];

    // Write port, independent of the read port
    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Read port, data one cycle after the request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule

// ---- src/rs_decoder_front_end.sv ----
// Decoder front end: input stream, syndrome, message buffer, timed output
// Behaviour
// RQ1 - Reset clears all state asynchronously
// RQ2 - Sequential logic updates on rising clock only
// RQ3 - Five-bit error count updated at last byte
// RQ4 - Fixed 97-cycle latency, last in first out
// RQ5 - Reduced variants: source waits for output end
// RQ6 - Gapless records need processor at triple rate
// RQ7 - Slower processor decodes, source inserts gaps
// RQ8 - Unsynchronised clock crossings are resynchronised
// RQ9 - No clock gating by default
// RQ10 - Buffer stores message bytes, drops parity
// RQ11 - Holding register keeps byte across pause
// RQ12 - Buffer is dual-port, written while read
// RQ13 - Buffer holds at least 198 bytes
// RQ14 - Syndromes evaluate word at alpha powers
// RQ15 - Serial syndrome takes one symbol per cycle
// RQ16 - Parallel level p absorbs p symbols
// RQ17 - Message first, highest index, then parity
// RQ18 - Field addition is bit-wise exclusive-or
// RQ19 - Multiplication uses polynomial 0x11D
// RQ20 - After N symbols feedback off, reload
// RQ21 - Last symbol pulses syndrome completion
// RQ22 - Uncorrectable page flags failure, passes data
// RQ23 - Output valid one cycle per byte
module rs_decoder_front_end (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] inByte,
    input wire logic inValid,
    input wire logic pauseIn,
    output logic [7:0] outByte,
    output logic outValid,
    output logic lastByte,
    output logic decodeFail,
    output logic [4:0] errorCount,
    output logic errorCountValid,
    output logic [127:0] syndrome,
    output logic syndromeDone,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    // Whole module state
    typedef struct packed {
        rs_front_pkg::out_state_t outState;
        logic [6:0] symCnt;
        logic [15:0][7:0] synd;
        logic syndDone;
        logic [7:0] wrPtr;
        logic [7:0] rdPtr;
        logic [6:0] timer;
        logic timerFail;
        logic [1:0] pendCnt;
        logic [1:0] pendFail;
        logic curFail;
        logic [6:0] issueCnt;
        logic rdIssue;
        logic rdLast;
        logic rdFail;
        logic [7:0] holdByte;
        logic holdValid;
        logic holdLast;
        logic holdFail;
        logic [7:0] outByte;
        logic outValid;
        logic lastByte;
        logic errValid;
        logic decodeFail;
        logic [4:0] errCount;
        logic swPause;
        logic [15:0] recCnt;
        logic [15:0] failCnt;
        logic awHave;
        logic [7:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic pauseSeen;
    } state_t;

    state_t cur_q; // Registered state
    state_t nxt_d; // Next state
    logic [15:0][7:0] syndFeed; // Accumulator next values
    logic [7:0] memData; // Buffer read data
    logic issue; // Buffer read this cycle
    logic memWrite; // Buffer write this cycle
    logic paused; // Pin or software pause
    logic lastIn; // Final symbol of a word
    logic push; // Record becomes due
    logic pop; // Record output starts
    logic [1:0] qCnt; // Pending count after pop
    logic [1:0] qFail; // Pending fail bits after pop
    logic emitNow; // Byte leaves this cycle
    logic [7:0] emitByte; // Byte leaving
    logic emitLast; // Byte closes a page
    logic emitFail; // Page was uncorrectable

    // Multiply by alpha, reducing by the field polynomial
    function automatic logic [7:0] mulAlpha(input logic [7:0] x);
        mulAlpha = {x[6:0], 1'b0} ^ (x[7] ? rs_front_pkg::GF_POLY_LOW : 8'h00); // [RQ19]
    endfunction

    // Multiply by alpha to the power n
    function automatic logic [7:0] mulAlphaPow(input logic [7:0] x, input logic [3:0] n);
        logic [7:0] r;
        r = x;
        for (int i = 0; i < 15; i++) begin
            if (4'(i) < n) begin
                r = mulAlpha(r);
            end
        end
        mulAlphaPow = r;
    endfunction

    // Register offsets that answer OKAY
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == rs_front_pkg::REG_CTRL) || (a == rs_front_pkg::REG_STATUS)
            || (a == rs_front_pkg::REG_LAST);
    endfunction

    // Serial Horner step per syndrome, one symbol per cycle
    for (genvar g = 0; g < rs_front_pkg::SYND_CNT; g++) begin : gSynd
        // First symbol of a word loads with feedback off [RQ20]
        assign syndFeed[g] = ((cur_q.symCnt == '0) ? 8'h00 : mulAlphaPow(cur_q.synd[g], 4'(g)))
            ^ inByte; // [RQ14] [RQ15] [RQ16] [RQ18]
    end

    // Single clock domain, processor work at main rate [RQ6] [RQ8] [RQ9]
    assign paused = pauseIn | cur_q.swPause;
    assign lastIn = inValid && (cur_q.symCnt == 7'(rs_front_pkg::N_SYM - 1));

    // Message buffer, dual-port so writes and reads overlap
    rs_msg_buffer buffer (
        .ref_clk(ref_clk),
        .rst(rst),
        .wrEn(memWrite),
        .wrAddr(cur_q.wrPtr),
        .wrData(inByte),
        .rdEn(issue),
        .rdAddr(cur_q.rdPtr),
        .rdData(memData)
    ); // [RQ12]

    // Next-state logic
    always_comb begin
        nxt_d = cur_q;
        issue = 1'b0;
        memWrite = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        emitNow = 1'b0;
        emitByte = 8'h00;
        emitLast = 1'b0;
        emitFail = 1'b0;
        nxt_d.syndDone = 1'b0;
        nxt_d.rdIssue = 1'b0;
        nxt_d.rdLast = 1'b0;
        nxt_d.rdFail = 1'b0;
        nxt_d.outValid = 1'b0;
        nxt_d.lastByte = 1'b0;
        nxt_d.errValid = 1'b0;
        // Latency timer counts down toward release
        if (cur_q.timer != '0) begin
            nxt_d.timer = cur_q.timer - 7'h01;
            push = (cur_q.timer == 7'h01); // [RQ4]
        end
        // Input side: message first, parity after [RQ17]
        if (inValid) begin
            nxt_d.synd = syndFeed;
            // Only message bytes go to the buffer
            if (cur_q.symCnt < 7'(rs_front_pkg::K_SYM)) begin
                memWrite = 1'b1; // [RQ10]
                nxt_d.wrPtr = (cur_q.wrPtr == 8'(rs_front_pkg::BUF_DEPTH - 1)) ? 8'h00
                    : cur_q.wrPtr + 8'h01; // [RQ13]
            end
            // Word complete: pulse, start timer, judge page
            if (lastIn) begin
                nxt_d.symCnt = '0;
                nxt_d.syndDone = 1'b1; // [RQ21]
                nxt_d.timer = rs_front_pkg::LAT_RELOAD; // [RQ4] [RQ7]
                nxt_d.timerFail = |syndFeed; // [RQ22]
            end else begin
                nxt_d.symCnt = cur_q.symCnt + 7'h01;
            end
        end
        // Output engine issues buffer reads
        unique case (cur_q.outState)
            rs_front_pkg::OUT_IDLE: begin
                // Start the oldest due page
                if (cur_q.pendCnt != 2'h0 && !paused) begin
                    pop = 1'b1;
                    issue = 1'b1;
                    nxt_d.curFail = cur_q.pendFail[0];
                    nxt_d.issueCnt = 7'h01;
                    nxt_d.outState = rs_front_pkg::OUT_RUN;
                end
            end
            rs_front_pkg::OUT_RUN: begin
                // One read per unpaused cycle
                if (!paused) begin
                    issue = 1'b1;
                    nxt_d.issueCnt = cur_q.issueCnt + 7'h01;
                    if (cur_q.issueCnt == 7'(rs_front_pkg::K_SYM - 1)) begin
                        nxt_d.rdLast = 1'b1;
                        nxt_d.rdFail = cur_q.curFail;
                        nxt_d.outState = rs_front_pkg::OUT_IDLE;
                    end
                end
            end
        endcase
        // Read pointer follows issued reads
        if (issue) begin
            nxt_d.rdIssue = 1'b1;
            nxt_d.rdPtr = (cur_q.rdPtr == 8'(rs_front_pkg::BUF_DEPTH - 1)) ? 8'h00
                : cur_q.rdPtr + 8'h01;
        end
        // Queue of due pages with their fail bits
        qCnt = cur_q.pendCnt - {1'b0, pop};
        qFail = pop ? {1'b0, cur_q.pendFail[1]} : cur_q.pendFail;
        if (push && qCnt != 2'h2) begin
            qFail[qCnt[0]] = cur_q.timerFail;
            qCnt = qCnt + 2'h1;
        end
        nxt_d.pendCnt = qCnt;
        nxt_d.pendFail = qFail;
        // Held byte goes out first on resume [RQ11]
        if (cur_q.holdValid && !paused) begin
            emitNow = 1'b1;
            emitByte = cur_q.holdByte;
            emitLast = cur_q.holdLast;
            emitFail = cur_q.holdFail;
            nxt_d.holdValid = 1'b0;
        end else if (cur_q.rdIssue) begin
            // Capture buffer output when pause arrives
            if (paused) begin
                nxt_d.holdByte = memData; // [RQ11]
                nxt_d.holdValid = 1'b1;
                nxt_d.holdLast = cur_q.rdLast;
                nxt_d.holdFail = cur_q.rdFail;
            end else begin
                emitNow = 1'b1;
                emitByte = memData;
                emitLast = cur_q.rdLast;
                emitFail = cur_q.rdFail;
            end
        end
        // Bus write address and data, either order
        if (awvalid && awready) begin
            nxt_d.awHave = 1'b1;
            nxt_d.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_d.wHave = 1'b1;
            nxt_d.wData = wdata;
            nxt_d.wStrb = wstrb;
        end
        if (cur_q.bvalid && bready) begin
            nxt_d.bvalid = 1'b0;
        end
        // Both halves present: perform the write
        if (nxt_d.awHave && nxt_d.wHave && !cur_q.bvalid) begin
            nxt_d.awHave = 1'b0;
            nxt_d.wHave = 1'b0;
            nxt_d.bvalid = 1'b1;
            nxt_d.bresp = isMapped(nxt_d.awAddr) ? rs_front_pkg::RESP_OKAY
                : rs_front_pkg::RESP_SLVERR;
            if (nxt_d.awAddr == rs_front_pkg::REG_CTRL && nxt_d.wStrb[0]) begin
                nxt_d.swPause = nxt_d.wData[rs_front_pkg::CTRL_PAUSE_BIT];
                // Self-clearing counter reset
                if (nxt_d.wData[rs_front_pkg::CTRL_CLEAR_BIT]) begin
                    nxt_d.recCnt = 16'h0000;
                    nxt_d.failCnt = 16'h0000;
                end
            end
        end
        // Output byte; page close updates count, after any clear
        if (emitNow) begin
            nxt_d.outByte = emitByte; // [RQ23]
            nxt_d.outValid = 1'b1; // [RQ23]
            if (emitLast) begin
                nxt_d.lastByte = 1'b1;
                nxt_d.errValid = 1'b1;
                nxt_d.errCount = rs_front_pkg::ERR_COUNT_NONE; // [RQ3]
                nxt_d.decodeFail = emitFail; // [RQ22]
                nxt_d.recCnt = nxt_d.recCnt + 16'h0001;
                nxt_d.failCnt = nxt_d.failCnt + {15'h0000, emitFail};
            end
        end
        // Bus read, one cycle answer
        if (cur_q.rvalid && rready) begin
            nxt_d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_d.rvalid = 1'b1;
            nxt_d.rresp = isMapped(araddr) ? rs_front_pkg::RESP_OKAY : rs_front_pkg::RESP_SLVERR;
            nxt_d.rdata = 32'h00000000;
            unique case (araddr)
                rs_front_pkg::REG_CTRL: begin
                    nxt_d.rdata[rs_front_pkg::CTRL_PAUSE_BIT] = cur_q.swPause;
                end
                rs_front_pkg::REG_STATUS: begin
                    nxt_d.rdata = {cur_q.failCnt, cur_q.recCnt};
                end
                rs_front_pkg::REG_LAST: begin
                    nxt_d.rdata[rs_front_pkg::LAST_FAIL_BIT] = cur_q.decodeFail;
                    nxt_d.rdata[rs_front_pkg::LAST_COUNT_LSB +: 5] = cur_q.errCount;
                    nxt_d.rdata[rs_front_pkg::LAST_BUSY_BIT] =
                        (cur_q.outState == rs_front_pkg::OUT_RUN);
                    nxt_d.rdata[rs_front_pkg::LAST_HOLD_BIT] = cur_q.holdValid;
                end
                default: begin
                    nxt_d.rdata = 32'h00000000;
                end
            endcase
        end
        // Helper: any pause since the last word ended
        nxt_d.pauseSeen = lastIn ? paused : (cur_q.pauseSeen | paused);
    end

    // State register, cleared asynchronously [RQ1] [RQ2]
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_q <= '0;
            cur_q.outState <= rs_front_pkg::OUT_IDLE;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // Port drive
    assign outByte = cur_q.outByte;
    assign outValid = cur_q.outValid;
    assign lastByte = cur_q.lastByte;
    assign decodeFail = cur_q.decodeFail;
    assign errorCount = cur_q.errCount;
    assign errorCountValid = cur_q.errValid;
    assign syndrome = cur_q.synd;
    assign syndromeDone = cur_q.syndDone;
    assign awready = !cur_q.awHave && !cur_q.bvalid;
    assign wready = !cur_q.wHave && !cur_q.bvalid;
    assign bvalid = cur_q.bvalid;
    assign bresp = cur_q.bresp;
    assign arready = !cur_q.rvalid;
    assign rvalid = cur_q.rvalid;
    assign rdata = cur_q.rdata;
    assign rresp = cur_q.rresp;

    // Checks on the design's own behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    latency_fixed_a: assert property ( // [RQ4]
        lastIn |-> ##97 (cur_q.outValid || cur_q.pauseSeen))
        else $error("first output byte not 97 cycles after last input");
    byte_cause_a: assert property ( // [RQ23]
        cur_q.outValid |-> $past(cur_q.rdIssue) || $past(cur_q.holdValid))
        else $error("output valid without a buffer byte");
    count_update_a: assert property ( // [RQ3]
        cur_q.errValid |-> cur_q.lastByte && cur_q.errCount == 5'h00)
        else $error("error count strobe not at last byte");
    fail_stable_a: assert property ( // [RQ22]
        !cur_q.errValid |-> $stable(cur_q.decodeFail))
        else $error("fail flag changed without count strobe");
    parity_drop_a: assert property ( // [RQ10]
        memWrite |-> cur_q.symCnt < 7'(rs_front_pkg::K_SYM))
        else $error("parity byte written to buffer");
    synd_pulse_a: assert property ( // [RQ21]
        lastIn |=> cur_q.syndDone ##1 !cur_q.syndDone)
        else $error("syndrome completion pulse wrong");
    synd_reload_a: assert property ( // [RQ20]
        (inValid && cur_q.symCnt == 7'h00) |=> cur_q.synd[0] == $past(inByte))
        else $error("first symbol not loaded into accumulator");
    hold_capture_a: assert property ( // [RQ11]
        (paused && cur_q.rdIssue && !cur_q.holdValid)
            |=> cur_q.holdValid && cur_q.holdByte == $past(memData))
        else $error("paused byte not held");
    pointer_range_a: assert property ( // [RQ13]
        cur_q.wrPtr < 8'(rs_front_pkg::BUF_DEPTH) && cur_q.rdPtr < 8'(rs_front_pkg::BUF_DEPTH))
        else $error("buffer pointer out of range");
endmodule

// ---- tb/rs_stream_partner.sv ----
// Upstream byte source and downstream consumer facing the decoder front end
module rs_stream_partner (
    input wire logic ref_clk,
    output logic [7:0] inByte,
    output logic inValid,
    input wire logic [7:0] outByte,
    input wire logic outValid,
    input wire logic lastByte,
    input wire logic decodeFail,
    input wire logic [4:0] errorCount,
    input wire logic errorCountValid,
    input wire logic [127:0] syndrome,
    input wire logic syndromeDone
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0; // Edge index
    int lastCyc[$]; // Edge of each final symbol
    logic [7:0] got[$]; // Output bytes in arrival order
    logic [7:0] gotFlag[$]; // Flags beside each byte
    int gotCyc[$]; // Edge of each byte
    logic [127:0] synd[$]; // Syndromes at completion
    int syndCyc[$]; // Edge of each completion pulse

    initial begin
        inByte = 8'h00;
        inValid = 1'b0;
    end

    // Free-running edge counter
    always @(posedge ref_clk) cyc <= cyc + 1;

    // Byte i of word w; word 0 is all zero
    function automatic logic [7:0] pat(input int w, input int i);
        return (w == 0) ? 8'h00 : 8'((w * 37 + i * 11) ^ (i >> 3));
    endfunction

    // Sends n symbols, message first, words may abut
    task automatic send_word(input int w, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            inByte <= pat(w, i);
            inValid <= 1'b1;
        end
        if (n == rs_front_pkg::N_SYM) lastCyc.push_back(cyc + 1);
    endtask

    // Drops valid, data line changes
    task automatic go_idle();
        @(posedge ref_clk);
        inValid <= 1'b0;
        inByte <= ~inByte;
    endtask

    // Forgets collected data
    task automatic clear_all();
        lastCyc.delete();
        got.delete();
        gotFlag.delete();
        gotCyc.delete();
        synd.delete();
        syndCyc.delete();
    endtask

    // Consumer takes every byte and pulse at once
    always @(posedge ref_clk) begin
        if (outValid === 1'b1) begin
            got.push_back(outByte);
            gotFlag.push_back({lastByte, errorCountValid, decodeFail, errorCount});
            gotCyc.push_back(cyc);
        end
        if (syndromeDone === 1'b1) begin
            synd.push_back(syndrome);
            syndCyc.push_back(cyc);
        end
    end
endmodule

// ---- tb/test_rs_decoder_front_end.sv ----
// Self-checking bench for the decoder front end
module test_rs_decoder_front_end;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, pauseIn, inValid, outValid, lastByte, decodeFail;
    logic errorCountValid, syndromeDone, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] inByte, outByte, awaddr, araddr;
    logic [4:0] errorCount;
    logic [127:0] syndrome;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int mismatches = 0; // Failed comparisons
    int num_checks = 0; // Comparisons made
    int wordsSent[$]; // Word of each expected page
    bit timed[$]; // Page ran without pause
    localparam int K = rs_front_pkg::K_SYM, N = rs_front_pkg::N_SYM;
    localparam logic [1:0] OK = rs_front_pkg::RESP_OKAY;

    rs_decoder_front_end uut (.ref_clk(ref_clk), .rst(rst), .inByte(inByte),
        .inValid(inValid), .pauseIn(pauseIn), .outByte(outByte), .outValid(outValid),
        .lastByte(lastByte), .decodeFail(decodeFail), .errorCount(errorCount),
        .errorCountValid(errorCountValid), .syndrome(syndrome), .syndromeDone(syndromeDone),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp));

    rs_stream_partner part (.ref_clk(ref_clk), .inByte(inByte), .inValid(inValid),
        .outByte(outByte), .outValid(outValid), .lastByte(lastByte),
        .decodeFail(decodeFail), .errorCount(errorCount),
        .errorCountValid(errorCountValid), .syndrome(syndrome),
        .syndromeDone(syndromeDone));

    // Clock generator
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Compares and counts
    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // A wait that ran out
    task automatic timeout();
        mismatches++;
        $display("wrong value at %0t: wait ran out", $time);
        test_done();
    endtask

    // Bus write, both halves together
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) timeout();
        check(bresp, er, "write response");
    endtask

    // Bus read with expected data and response
    task automatic reg_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) timeout();
        check(rdata, ed, "read data");
        check(rresp, er, "read response");
    endtask

    // Bounded wait for a byte total
    task automatic wait_bytes(input int total);
        for (int n = 0; n < 3000 && part.got.size() < total; n++) @(posedge ref_clk);
        if (part.got.size() < total) timeout();
    endtask

    // Field product over 0x11D
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (b[k]) p ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? rs_front_pkg::GF_POLY_LOW : 8'h00);
        end
        return p;
    endfunction

    // Word at alpha^0..alpha^15, first symbol highest power
    function automatic logic [127:0] expSynd(input int w);
        logic [127:0] s;
        logic [7:0] root, acc;
        root = 8'h01;
        for (int j = 0; j < 16; j++) begin
            acc = 8'h00;
            for (int i = 0; i < N; i++) acc = gmul(acc, root) ^ part.pat(w, i);
            s[8*j +: 8] = acc;
            root = gmul(root, 8'h02);
        end
        return s;
    endfunction

    // Every page: syndrome, bytes and end flags; timing only for unpaused pages
    task automatic verify_pages();
        int w, b;
        check(part.got.size(), wordsSent.size() * K, "byte total");
        for (int p = 0; p < wordsSent.size(); p++) begin
            w = wordsSent[p];
            b = p * K;
            check(part.synd[p], expSynd(w), "syndrome");
            check(part.syndCyc[p] - part.lastCyc[p], 32'h1, "syndrome pulse");
            if (timed[p]) check(part.gotCyc[b] - part.lastCyc[p], 32'h61, "latency");
            for (int i = 0; i < K; i++) begin
                check(part.got[b + i], part.pat(w, i), "byte");
                check(part.gotFlag[b + i], (i == K - 1) ? {2'b11, w != 0, 5'h00} : {2'b00,
                    p > 0 && wordsSent[p - 1] != 0, 5'h00}, "page end");
                if (timed[p]) check(part.gotCyc[b + i] - part.gotCyc[b], i, "spacing");
            end
        end
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        {pauseIn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check({outValid, syndromeDone, errorCountValid, bvalid, rvalid, awready, arready},
            7'h03, "reset outputs");
        reg_read(rs_front_pkg::REG_STATUS, 32'h0, OK);
        reg_read(8'h0C, 32'h0, rs_front_pkg::RESP_SLVERR);
        reg_write(8'h10, 32'h1, rs_front_pkg::RESP_SLVERR);
        reg_read(rs_front_pkg::REG_CTRL, 32'h0, OK);
        // Clean word, then two words back to back
        part.send_word(0, N);
        part.go_idle();
        wait_bytes(K);
        reg_read(rs_front_pkg::REG_LAST, 32'h0, OK);
        part.send_word(1, N);
        part.send_word(2, N);
        part.go_idle();
        wordsSent = '{0, 1, 2};
        timed = '{1, 1, 1};
        wait_bytes(3 * K);
        reg_read(rs_front_pkg::REG_LAST, 32'h1, OK);
        // Pause by pin, then by register, mid-page
        part.send_word(3, N);
        part.go_idle();
        wordsSent.push_back(3);
        timed.push_back(0);
        repeat (100) @(posedge ref_clk);
        pauseIn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pauseIn <= 1'b0;
        reg_write(rs_front_pkg::REG_CTRL, 32'h1, OK);
        reg_read(rs_front_pkg::REG_CTRL, 32'h1, OK);
        repeat (6) @(posedge ref_clk);
        reg_write(rs_front_pkg::REG_CTRL, 32'h0, OK);
        wait_bytes(4 * K);
        reg_read(rs_front_pkg::REG_STATUS, 32'h00030004, OK);
        reg_write(rs_front_pkg::REG_CTRL, 32'h2, OK);
        reg_read(rs_front_pkg::REG_STATUS, 32'h0, OK);
        reg_read(rs_front_pkg::REG_CTRL, 32'h0, OK);
        verify_pages();
        // Reset mid-word, then a fresh word
        part.send_word(5, 50);
        part.go_idle();
        rst <= 1'b1;
        @(posedge ref_clk);
        check({outValid, syndromeDone, errorCountValid, awready}, 4'h1, "mid reset");
        rst <= 1'b0;
        part.clear_all();
        part.send_word(0, N);
        part.go_idle();
        wordsSent = '{0};
        timed = '{1};
        wait_bytes(K);
        reg_read(rs_front_pkg::REG_STATUS, 32'h1, OK);
        verify_pages();
        test_done();
    end
endmodule
